// [design/adpmc_pin_mux.sv]
`timescale 1ns/10ps

module adpmc_pin_mux (
	// Control registers
	input wire logic [15:0] dirReg,
	input wire logic [15:0] funcReg,
	input wire logic [15:0] latchReg,
	// Pads
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut,
	output logic [15:0] pinOutEnN,
	// External bus interface
	input wire logic [15:0] busOut,
	input wire logic [15:0] busDriveEn,
	output logic [15:0] busIn,
	// Value seen by a port read
	output logic [15:0] portRead
);

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : gPin
			// Bus function hands the pad to the bus interface
			assign pinOutEnN[i] = funcReg[i] ? ~busDriveEn[i] : dirReg[i]; // [RQ1] [RQ11]
			assign pinOut[i] = funcReg[i] ? busOut[i] : latchReg[i]; // [RQ10] [RQ11]
			assign busIn[i] = funcReg[i] & pinIn[i];
			assign portRead[i] = dirReg[i] ? pinIn[i] : latchReg[i]; // [RQ12]
		end
	endgenerate

endmodule

// [design/adpmc_pkg.sv]
package adpmc_pkg;

	// Port geometry
	localparam int PORT_W = 16;
	localparam int BYTE_W = 8;
	localparam int LOW_LSB = 0;
	localparam int HIGH_LSB = 8;

	// Register indices as printed; the bus address is four times the index
	localparam logic [31:0] LATCH_IDX = 32'hfffff004;
	localparam logic [31:0] LATCH_HIGH_IDX = 32'hfffff005;
	localparam logic [31:0] DIR_IDX = 32'hfffff024;
	localparam logic [31:0] DIR_HIGH_IDX = 32'hfffff025;
	localparam logic [31:0] FUNC_IDX = 32'hfffff044;
	localparam logic [31:0] FUNC_HIGH_IDX = 32'hfffff045;

	// Byte addresses on APB
	localparam logic [31:0] LATCH_ADDR = {LATCH_IDX[29:0], 2'b00};
	localparam logic [31:0] LATCH_HIGH_ADDR = {LATCH_HIGH_IDX[29:0], 2'b00};
	localparam logic [31:0] DIR_ADDR = {DIR_IDX[29:0], 2'b00};
	localparam logic [31:0] DIR_HIGH_ADDR = {DIR_HIGH_IDX[29:0], 2'b00};
	localparam logic [31:0] FUNC_ADDR = {FUNC_IDX[29:0], 2'b00};
	localparam logic [31:0] FUNC_HIGH_ADDR = {FUNC_HIGH_IDX[29:0], 2'b00};

	// Reset values
	localparam logic [15:0] LATCH_RESET = 16'h0000;
	localparam logic [15:0] DIR_RESET = 16'hffff;
	localparam logic [15:0] FUNC_RESET = 16'h0000;

	// Answer to an unmapped read
	localparam logic [31:0] READ_NONE = 32'h0000_0000;

endpackage

// [design/adpmc_port.sv]
// Behaviour
// (RQ1) Direction bit clear makes its pin an output, set makes it an input.
// (RQ2) Direction register resets to all ones, so every pin starts as input.
// (RQ3) Direction register takes word access; low and high halves take byte access.
// (RQ4) Direction bits 8 to 15 are reached as bits 0 to 7 of the high alias.
// (RQ5) Function bit set routes the pin to the bus line; resets to zero.
// (RQ6) Function register takes word access; low and high halves take byte access.
// (RQ7) Function bits 8 to 15 are reached as bits 0 to 7 of the high alias.
// (RQ8) Software keeps upper pins in port function for separate 8-bit bus mode.
// (RQ9) Software should pick port or bus function to suit the attached memory.
// (RQ10) Output latch, cleared at reset, drives port-function output pins.
// (RQ11) In bus function the bus interface drives data and enable of the pin.
// (RQ12) Port read gives pin level for inputs and latch value for outputs.
`timescale 1ns/10ps

module adpmc_port (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pads
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut,
	output logic [15:0] pinOutEnN,
	// External bus interface
	input wire logic [15:0] busOut,
	input wire logic [15:0] busDriveEn,
	output logic [15:0] busIn,
	output logic [15:0] busSelect
);

	typedef struct packed {
		logic [31:0] rdata;
		logic err;
	} adpmc_bus_state_t;

	adpmc_bus_state_t state;
	adpmc_bus_state_t next_state;

	logic [15:0] dirReg;
	logic [15:0] funcReg;
	logic [15:0] latchReg;
	logic [15:0] portRead;

	logic setupPhase;
	logic writeTaken;
	logic hitLatch;
	logic hitLatchHigh;
	logic hitDir;
	logic hitDirHigh;
	logic hitFunc;
	logic hitFuncHigh;
	logic anyHit;
	logic [31:0] readValue;

	// Write enables per byte half
	logic dirWrLow;
	logic dirWrHigh;
	logic funcWrLow;
	logic funcWrHigh;
	logic latchWrLow;
	logic latchWrHigh;
	logic [7:0] highByteData;

	// Address decode
	assign hitLatch = (paddr == adpmc_pkg::LATCH_ADDR);
	assign hitLatchHigh = (paddr == adpmc_pkg::LATCH_HIGH_ADDR);
	assign hitDir = (paddr == adpmc_pkg::DIR_ADDR);
	assign hitDirHigh = (paddr == adpmc_pkg::DIR_HIGH_ADDR);
	assign hitFunc = (paddr == adpmc_pkg::FUNC_ADDR);
	assign hitFuncHigh = (paddr == adpmc_pkg::FUNC_HIGH_ADDR);
	assign anyHit = hitLatch | hitLatchHigh | hitDir | hitDirHigh | hitFunc | hitFuncHigh;

	assign setupPhase = psel & ~penable;
	assign writeTaken = psel & penable & pwrite & anyHit;

	// The base word carries bits 15:8 in lane 1, the high alias in lane 0
	assign highByteData = pwdata[7:0];

	assign dirWrLow = writeTaken & hitDir & pstrb[0]; // [RQ3]
	assign dirWrHigh = writeTaken & ((hitDir & pstrb[1]) | (hitDirHigh & pstrb[0])); // [RQ3] [RQ4]
	assign funcWrLow = writeTaken & hitFunc & pstrb[0]; // [RQ6]
	assign funcWrHigh = writeTaken & ((hitFunc & pstrb[1]) | (hitFuncHigh & pstrb[0])); // [RQ6] [RQ7]
	assign latchWrLow = writeTaken & hitLatch & pstrb[0];
	assign latchWrHigh = writeTaken & ((hitLatch & pstrb[1]) | (hitLatchHigh & pstrb[0]));

	adpmc_reg16 #(
		.RESET_VAL(adpmc_pkg::DIR_RESET) // [RQ2]
	) uDir (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrLow(dirWrLow),
		.wrHigh(dirWrHigh),
		.lowData(pwdata[7:0]),
		.highData(hitDirHigh ? highByteData : pwdata[15:8]), // [RQ4]
		.value(dirReg)
	);

	adpmc_reg16 #(
		.RESET_VAL(adpmc_pkg::FUNC_RESET) // [RQ5]
	) uFunc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrLow(funcWrLow),
		.wrHigh(funcWrHigh),
		.lowData(pwdata[7:0]),
		.highData(hitFuncHigh ? highByteData : pwdata[15:8]), // [RQ7]
		.value(funcReg)
	);

	adpmc_reg16 #(
		.RESET_VAL(adpmc_pkg::LATCH_RESET) // [RQ10]
	) uLatch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrLow(latchWrLow),
		.wrHigh(latchWrHigh),
		.lowData(pwdata[7:0]),
		.highData(hitLatchHigh ? highByteData : pwdata[15:8]),
		.value(latchReg)
	);

	adpmc_pin_mux uMux (
		.dirReg(dirReg),
		.funcReg(funcReg),
		.latchReg(latchReg),
		.pinIn(pinIn),
		.pinOut(pinOut),
		.pinOutEnN(pinOutEnN),
		.busOut(busOut),
		.busDriveEn(busDriveEn),
		.busIn(busIn),
		.portRead(portRead)
	);

	// Read multiplexer; halves read back in the low byte of the word
	always_comb begin
		readValue = adpmc_pkg::READ_NONE;
		if (hitDir) begin
			readValue = {16'h0000, dirReg}; // [RQ3]
		end else if (hitDirHigh) begin
			readValue = {24'h000000, dirReg[15:8]}; // [RQ4]
		end else if (hitFunc) begin
			readValue = {16'h0000, funcReg}; // [RQ6]
		end else if (hitFuncHigh) begin
			readValue = {24'h000000, funcReg[15:8]}; // [RQ7]
		end else if (hitLatch) begin
			readValue = {16'h0000, portRead}; // [RQ12]
		end else if (hitLatchHigh) begin
			readValue = {24'h000000, portRead[15:8]}; // [RQ12]
		end
	end

	// Read data and error are captured in the setup cycle
	always_comb begin
		next_state = state;
		if (setupPhase) begin
			next_state.rdata = pwrite ? adpmc_pkg::READ_NONE : readValue;
			next_state.err = ~anyHit;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '{rdata: adpmc_pkg::READ_NONE, err: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.rdata;
	assign pready = 1'b1;
	assign pslverr = state.err & psel & penable;
	assign busSelect = funcReg; // [RQ5]

	// Checks

	AST_DIR_RESET: assert property ( // [RQ2]
		@(posedge sys_clk) $rose(rst_n) |-> (dirReg == 16'hffff && pinOutEnN == 16'hffff)
	) else $error("Direction register not all ones after reset");

	AST_FUNC_RESET: assert property ( // [RQ5]
		@(posedge sys_clk) $rose(rst_n) |-> (funcReg == 16'h0000 && busSelect == 16'h0000)
	) else $error("Function register not zero after reset");

	AST_DIR_WORD_WRITE: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::DIR_ADDR && pstrb[1:0] == 2'b11)
		|=> dirReg == $past(pwdata[15:0])
	) else $error("Word write to direction register lost");

	AST_DIR_HIGH_ALIAS: assert property ( // [RQ4]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::DIR_HIGH_ADDR && pstrb[0])
		|=> (dirReg[15:8] == $past(pwdata[7:0]) && dirReg[7:0] == $past(dirReg[7:0]))
	) else $error("High alias write to direction register misplaced");

	AST_FUNC_LOW_BYTE: assert property ( // [RQ6]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::FUNC_ADDR && pstrb[1:0] == 2'b01)
		|=> (funcReg[7:0] == $past(pwdata[7:0]) && funcReg[15:8] == $past(funcReg[15:8]))
	) else $error("Low byte write to function register wrong");

	AST_FUNC_HIGH_ALIAS: assert property ( // [RQ7]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == adpmc_pkg::FUNC_HIGH_ADDR)
		|=> (psel && penable) |-> prdata == {24'h000000, $past(funcReg[15:8])}
	) else $error("High alias read of function register wrong");

	AST_PORT_OUTPUT: assert property ( // [RQ10] [RQ1]
		@(posedge sys_clk) disable iff (!rst_n)
		((~funcReg & ~dirReg & (pinOut ^ latchReg)) == 16'h0000)
		&& ((~funcReg & (pinOutEnN ^ dirReg)) == 16'h0000)
	) else $error("Port pin not driven from latch and direction");

	AST_BUS_OVERRIDE: assert property ( // [RQ11]
		@(posedge sys_clk) disable iff (!rst_n)
		((funcReg & ((pinOut ^ busOut) | ~(pinOutEnN ^ busDriveEn))) == 16'h0000)
	) else $error("Bus function pin not under bus control");

	AST_PORT_READBACK: assert property ( // [RQ12]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == adpmc_pkg::LATCH_ADDR)
		|=> prdata[15:0] == (($past(dirReg) & $past(pinIn)) | (~$past(dirReg) & $past(latchReg)))
	) else $error("Port read does not mix pin level and latch");

	AST_UNMAPPED: assert property ( // [RQ3] [RQ6]
		@(posedge sys_clk) disable iff (!rst_n)
		(setupPhase && !anyHit) |=> (psel && penable) |-> (pslverr && prdata == 32'h0000_0000)
	) else $error("Unmapped access not answered with error");

	AST_DIR_LOW_BYTE: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::DIR_ADDR && pstrb[1:0] == 2'b01)
		|=> (dirReg[7:0] == $past(pwdata[7:0]) && dirReg[15:8] == $past(dirReg[15:8]))
	) else $error("Low byte write to direction register wrong");

	AST_DIR_HIGH_BYTE: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::DIR_ADDR && pstrb[1:0] == 2'b10)
		|=> (dirReg[15:8] == $past(pwdata[15:8]) && dirReg[7:0] == $past(dirReg[7:0]))
	) else $error("High byte write to direction register wrong");

	AST_DIR_WORD_READ: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == adpmc_pkg::DIR_ADDR)
		|=> (psel && penable) |-> prdata == {16'h0000, $past(dirReg)}
	) else $error("Word read of direction register wrong");

	AST_DIR_ALIAS_READ: assert property ( // [RQ4]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == adpmc_pkg::DIR_HIGH_ADDR)
		|=> (psel && penable) |-> prdata == {24'h000000, $past(dirReg[15:8])}
	) else $error("High alias read of direction register wrong");

	AST_DIR_HOLD: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		!(writeTaken && (hitDir || hitDirHigh)) |=> $stable(dirReg)
	) else $error("Direction register changed without a write");

	AST_FUNC_WORD_WRITE: assert property ( // [RQ6]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::FUNC_ADDR && pstrb[1:0] == 2'b11)
		|=> funcReg == $past(pwdata[15:0])
	) else $error("Word write to function register lost");

	AST_FUNC_HIGH_WRITE: assert property ( // [RQ7]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::FUNC_HIGH_ADDR && pstrb[0])
		|=> (funcReg[15:8] == $past(pwdata[7:0]) && funcReg[7:0] == $past(funcReg[7:0]))
	) else $error("High alias write to function register misplaced");

	AST_FUNC_WORD_READ: assert property ( // [RQ6]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == adpmc_pkg::FUNC_ADDR)
		|=> (psel && penable) |-> prdata == {16'h0000, $past(funcReg)}
	) else $error("Word read of function register wrong");

	AST_FUNC_HOLD: assert property ( // [RQ5]
		@(posedge sys_clk) disable iff (!rst_n)
		!(writeTaken && (hitFunc || hitFuncHigh)) |=> $stable(funcReg)
	) else $error("Function register changed without a write");

	AST_LATCH_WORD_WRITE: assert property ( // [RQ10]
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == adpmc_pkg::LATCH_ADDR && pstrb[1:0] == 2'b11)
		|=> latchReg == $past(pwdata[15:0])
	) else $error("Word write to output latch lost");

	AST_LATCH_HOLD: assert property ( // [RQ10]
		@(posedge sys_clk) disable iff (!rst_n)
		!(writeTaken && (hitLatch || hitLatchHigh)) |=> $stable(latchReg)
	) else $error("Output latch changed without a write");

	AST_LATCH_RESET: assert property ( // [RQ10]
		@(posedge sys_clk) $rose(rst_n) |-> (latchReg == 16'h0000 && pinOut == 16'h0000)
	) else $error("Output latch not cleared after reset");

endmodule

// [design/adpmc_reg16.sv]
`timescale 1ns/10ps

module adpmc_reg16 #(
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Byte-lane writes
	input wire logic wrLow,
	input wire logic wrHigh,
	input wire logic [7:0] lowData,
	input wire logic [7:0] highData,
	// Stored value
	output logic [15:0] value
);

	typedef struct packed {
		logic [15:0] value;
	} adpmc_reg_state_t;

	adpmc_reg_state_t state;
	adpmc_reg_state_t next_state;

	always_comb begin
		next_state = state;
		if (wrLow) begin
			next_state.value[7:0] = lowData;
		end
		if (wrHigh) begin
			next_state.value[15:8] = highData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '{value: RESET_VAL};
		end else begin
			state <= next_state;
		end
	end

	assign value = state.value;

endmodule

// [verif/addr_data_port_mode_control_bench.sv]
`timescale 1ns/10ps

module addr_data_port_mode_control_bench;
	localparam logic [31:0] D = adpmc_pkg::DIR_ADDR;
	localparam logic [31:0] DH = adpmc_pkg::DIR_HIGH_ADDR;
	localparam logic [31:0] F = adpmc_pkg::FUNC_ADDR;
	localparam logic [31:0] FH = adpmc_pkg::FUNC_HIGH_ADDR;
	localparam logic [31:0] L = adpmc_pkg::LATCH_ADDR;
	localparam logic [31:0] LH = adpmc_pkg::LATCH_HIGH_ADDR;
	localparam logic [31:0] U = 32'h0000_0100;
	typedef struct packed {
		logic w;
		logic [31:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [31:0] r;
		logic e;
	} adpmc_row_t;
	// Write, address, data, strobes, read data, error
	localparam adpmc_row_t ROWS [22] = '{
		'{1'b0, D, '0, 4'h0, 32'h0000ffff, 1'b0},
		'{1'b0, F, '0, 4'h0, '0, 1'b0},
		'{1'b1, D, 32'h0000a55a, 4'h3, '0, 1'b0},
		'{1'b0, D, '0, 4'h0, 32'h0000a55a, 1'b0},
		'{1'b0, DH, '0, 4'h0, 32'h000000a5, 1'b0},
		'{1'b1, DH, 32'h0000003c, 4'h1, '0, 1'b0},
		'{1'b1, D, 32'h000000ff, 4'h1, '0, 1'b0},
		'{1'b0, D, '0, 4'h0, 32'h00003cff, 1'b0},
		'{1'b1, D, 32'h0000c300, 4'h2, '0, 1'b0},
		'{1'b0, DH, '0, 4'h0, 32'h000000c3, 1'b0},
		'{1'b1, F, 32'h00001234, 4'h2, '0, 1'b0},
		'{1'b1, FH, 32'h000000f0, 4'h1, '0, 1'b0},
		'{1'b0, F, '0, 4'h0, 32'h0000f000, 1'b0},
		'{1'b0, FH, '0, 4'h0, 32'h000000f0, 1'b0},
		'{1'b1, F, 32'h0000ffff, 4'hc, '0, 1'b0},
		'{1'b0, F, '0, 4'h0, 32'h0000f000, 1'b0},
		'{1'b1, F, 32'h000000a5, 4'h1, '0, 1'b0},
		'{1'b0, F, '0, 4'h0, 32'h0000f0a5, 1'b0},
		'{1'b1, LH, 32'h0000005a, 4'h1, '0, 1'b0},
		'{1'b0, LH, '0, 4'h0, 32'h00000018, 1'b0},
		'{1'b0, U, '0, 4'h0, '0, 1'b1},
		'{1'b1, U, 32'hffffffff, 4'hf, '0, 1'b1}
	};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] pinIn = '0;
	logic [15:0] busOut = '0;
	logic [15:0] busDriveEn = '0;
	logic [15:0] pinOut;
	logic [15:0] pinOutEnN;
	logic [15:0] busIn;
	logic [15:0] busSelect;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int cmp_count = 0;

	adpmc_port adpmc_port_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
		.busOut(busOut), .busDriveEn(busDriveEn), .busIn(busIn), .busSelect(busSelect)
	);

	always #20 sys_clk = ~sys_clk;

	task finish_test;
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			chk("pready", 32'h0000_0001, {31'h0, pready});
			finish_test();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Port reads are compared on port-function pins only
	task pins(input logic [15:0] f, dir, lat, pi, bo, be);
		pinIn <= pi;
		busOut <= bo;
		busDriveEn <= be;
		apb(1'b1, F, {16'h0000, f}, 4'h3);
		apb(1'b1, D, {16'h0000, dir}, 4'h3);
		apb(1'b1, L, {16'h0000, lat}, 4'h3);
		apb(1'b0, L, '0, 4'h0);
		chk("portRead", {16'h0000, ((dir & pi) | (~dir & lat)) & ~f}, rd & {16'h0000, ~f});
		chk("pinOutEnN", {16'h0000, (f & ~be) | (~f & dir)}, {16'h0000, pinOutEnN});
		chk("pinOut", {16'h0000, (f & bo) | (~f & lat)}, {16'h0000, pinOut});
		chk("busIn", {16'h0000, pi & f}, {16'h0000, busIn});
		chk("busSelect", {16'h0000, f}, {16'h0000, busSelect});
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 22; k++) begin
			apb(ROWS[k].w, ROWS[k].a, ROWS[k].d, ROWS[k].s);
			chk("prdata", ROWS[k].r, rd);
			chk("pslverr", {31'h0, ROWS[k].e}, {31'h0, er});
		end
		pins(16'h0f00, 16'hf0f0, 16'h00a5, 16'h3c3c, 16'h5a5a, 16'h0300);
		pins(16'h0000, 16'h00ff, 16'h1234, 16'hc3c3, 16'hffff, 16'hffff);
		pins(16'hffff, 16'h0000, 16'hffff, 16'h9696, 16'h0f0f, 16'hf00f);
		// Eight-bit bus: upper pins stay in port function
		pins(16'h00ff, 16'hff00, 16'h5a00, 16'h0f0f, 16'ha5a5, 16'h00f0);
		// Second reset in mid-run
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("pinOutEnN", 32'h0000ffff, {16'h0000, pinOutEnN});
		chk("pinOut", '0, {16'h0000, pinOut});
		chk("busSelect", '0, {16'h0000, busSelect});
		rst_n <= 1'b1;
		apb(1'b0, D, '0, 4'h0);
		chk("dirReset", 32'h0000ffff, rd);
		apb(1'b0, F, '0, 4'h0);
		chk("funcReset", '0, rd);
		finish_test();
	end
endmodule
